// ### hdl/tkr_pkg.sv
// Purpose: Shared constants for the timekeeping SRAM block and its host end
// Assumes: 100 MHz CLOCK; 19-bit byte address; 8-bit data
// Notes:   Clock registers occupy the top eight byte locations
package tkr_pkg;
  localparam int          ADDR_W        = 19;
  localparam int          DATA_W        = 8;
  localparam int          CLK_HZ        = 100_000_000;
  // Register offsets
  localparam logic [18:0] OFS_CONTROL   = 19'h7fff8;
  localparam logic [18:0] OFS_SECONDS   = 19'h7fff9;
  localparam logic [18:0] OFS_MINUTES   = 19'h7fffa;
  localparam logic [18:0] OFS_HOURS     = 19'h7fffb;
  localparam logic [18:0] OFS_WEEKDAY   = 19'h7fffc;
  localparam logic [18:0] OFS_DATE      = 19'h7fffd;
  localparam logic [18:0] OFS_MONTH     = 19'h7fffe;
  localparam logic [18:0] OFS_YEAR      = 19'h7ffff;
  // Field positions
  localparam int          BIT_WRITE     = 7;
  localparam int          BIT_READ      = 6;
  localparam int          BIT_OSC_STOP  = 7;
  localparam int          BIT_FREQ      = 6;
  // Field masks of the counting bits; other bits are storage, seconds bit 7 and weekday bit 6 being control bits
  localparam logic [7:0]  MSK_SECONDS   = 8'h7f;
  localparam logic [7:0]  MSK_MINUTES   = 8'h7f;
  localparam logic [7:0]  MSK_HOURS     = 8'h3f;
  localparam logic [7:0]  MSK_WEEKDAY   = 8'h07;
  localparam logic [7:0]  MSK_DATE      = 8'h3f;
  localparam logic [7:0]  MSK_MONTH     = 8'h1f;
  localparam logic [7:0]  MSK_YEAR      = 8'hff;
  // Reset values of the control byte and the counters
  localparam logic [7:0]  RST_CONTROL   = 8'h00;
  localparam logic [7:0]  RST_BCD_ONE   = 8'h01;
  localparam logic [7:0]  RST_BCD_ZERO  = 8'h00;
  // Timing
  localparam int          FREQ_TEST_HZ  = 512;
  localparam int          TOGGLE_HZ     = 2 * FREQ_TEST_HZ;
  localparam int          READ_CLR_US   = 500;
  localparam int          READ_CLR_CYC  = (READ_CLR_US * (CLK_HZ / 1_000_000));
endpackage

// ### hdl/tkr_bus_if.sv
// Purpose: Asynchronous SRAM-style bus joining host and timekeeping device
// Assumes: Data bus resolved from the two output enables
// Notes:   Strobes are active low
`timescale 1ns/1ps
`default_nettype none
interface tkr_bus_if;
  logic [18:0] addr;
  logic        chip_sel_n;
  logic        out_drv_n;
  logic        wr_strobe_n;
  logic [7:0]  host_dq_o;
  logic        host_dq_oe;
  logic [7:0]  dev_dq_o;
  logic        dev_dq_oe;
  logic        power_fail_flag_n_o;
  logic        power_fail_flag_n_oe;
  logic [7:0]  dq;
  logic        power_fail_flag_n;

  // Wire resolution: whichever end enables drives, the device if both do; pullup on the flag
  assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : 8'hff);
  assign power_fail_flag_n = power_fail_flag_n_oe ? power_fail_flag_n_o : 1'b1;

  modport device (
    input  addr, chip_sel_n, out_drv_n, wr_strobe_n, dq,
    output dev_dq_o, dev_dq_oe, power_fail_flag_n_o, power_fail_flag_n_oe
  );
  modport host (
    output addr, chip_sel_n, out_drv_n, wr_strobe_n, host_dq_o, host_dq_oe,
    input  dq, power_fail_flag_n
  );
endinterface
`default_nettype wire

// ### hdl/tkr_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input comes from outside the CLOCK domain
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module tkr_sync #(
  parameter int          W        = 1,
  parameter logic [W-1:0] INIT    = '0
) (
  // Clock and reset
  input  wire logic         CLOCK,
  input  wire logic         RESET,
  // Data
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge CLOCK or posedge RESET)
    if (RESET)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end
    else
    begin
      s1_r <= D;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_agree
      always_ff @(posedge CLOCK or posedge RESET)
        if (RESET)
          Q[i] <= INIT[i];
        else if (s2_r[i] == s3_r[i])
          Q[i] <= s3_r[i];
    end
  endgenerate
endmodule
`default_nettype wire

// ### hdl/tkr_device.sv
// Purpose: Byte-wide SRAM with timekeeping registers in the top eight bytes
// Assumes: Bus pins synchronised to CLOCK; POWER_FAIL is a level from a monitor
// Notes:   Pins pass a three-stage synchroniser before use
`timescale 1ns/1ps
`default_nettype none
module tkr_device #(
  parameter int MEM_WORDS = 524288,
  parameter int TICK_DIV  = tkr_pkg::CLK_HZ / tkr_pkg::TOGGLE_HZ
) (
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic RESET,
  // Supply monitor
  input  wire logic POWER_FAIL,
  // Bus
  tkr_bus_if.device BUS
);
  // Index width needs a power-of-two depth; divider needs two states
  if (MEM_WORDS < 8 || MEM_WORDS > 524288 || TICK_DIV < 2 ||
      (MEM_WORDS & (MEM_WORDS - 1)) != 0)
  begin : g_bad_params
    $error("tkr_device: unsupported parameters");
  end

  //--------------------------------------------------------------
  // Input synchronisation
  //--------------------------------------------------------------
  logic [18:0] addr;
  logic [7:0]  din;
  logic        cs_pin_n;
  logic        oe_n;
  logic        we_pin_n;
  logic        pwr_ok;
  tkr_sync #(.W(19)) u_sa (.CLOCK(CLOCK), .RESET(RESET), .D(BUS.addr), .Q(addr));
  tkr_sync #(.W(8))  u_sd (.CLOCK(CLOCK), .RESET(RESET), .D(BUS.dq), .Q(din));
  tkr_sync #(.W(4), .INIT(4'hf)) u_sc (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .D({BUS.chip_sel_n, BUS.out_drv_n, BUS.wr_strobe_n, ~POWER_FAIL}),
    .Q({cs_pin_n, oe_n, we_pin_n, pwr_ok})
  );

  //--------------------------------------------------------------
  // Access decode
  //--------------------------------------------------------------
  logic cs_n;
  logic wr_act;
  logic wr_act_r;
  logic wr_end;
  logic is_clk;
  assign cs_n   = cs_pin_n | ~pwr_ok;
  assign wr_act = ~cs_n & ~we_pin_n;
  assign wr_end = wr_act_r & ~wr_act;
  assign is_clk = (addr >= tkr_pkg::OFS_CONTROL);

  always_ff @(posedge CLOCK or posedge RESET)
    if (RESET)
      wr_act_r <= 1'b0;
    else
      wr_act_r <= wr_act;

  //--------------------------------------------------------------
  // Storage: plain RAM and visible clock bytes
  //--------------------------------------------------------------
  logic [7:0] mem [MEM_WORDS];
  logic [7:0] vis_r [8];
  logic [2:0] ri;
  logic [7:0] ctl;
  logic       frozen;
  assign ri     = addr[2:0];
  assign ctl    = vis_r[0];
  assign frozen = ctl[tkr_pkg::BIT_READ] | ctl[tkr_pkg::BIT_WRITE];

  // Data latched at the end of the strobe, when data is settled
  always_ff @(posedge CLOCK)
    if (wr_end && !is_clk)
      mem[addr[$clog2(MEM_WORDS)-1:0]] <= din;

  //--------------------------------------------------------------
  // Counters
  //--------------------------------------------------------------
  logic [7:0] sec_r, min_r, hr_r, wd_r, dt_r, mo_r, yr_r;
  logic [31:0] div_r;
  logic        tick;
  logic [9:0]  sub_r;
  logic        osc_on;
  logic        toggle_r;
  logic        wr_bit_r;
  logic        load;
  assign osc_on = ~vis_r[1][tkr_pkg::BIT_OSC_STOP];
  assign tick   = osc_on && (div_r == 32'(TICK_DIV - 1));
  assign load   = wr_bit_r & ~ctl[tkr_pkg::BIT_WRITE];

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = (y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                 : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8));
    case (m)
      8'h02:                      last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default:                    last_day = 8'h31;
    endcase
  endfunction

  always_ff @(posedge CLOCK or posedge RESET)
    if (RESET)
    begin
      div_r    <= '0;
      sub_r    <= '0;
      toggle_r <= 1'b0;
      wr_bit_r <= 1'b0;
    end
    else
    begin
      wr_bit_r <= ctl[tkr_pkg::BIT_WRITE];
      div_r    <= (!osc_on || tick) ? '0 : div_r + 32'h1;
      if (tick)
      begin
        sub_r    <= sub_r + 10'h1;
        toggle_r <= ~toggle_r;
      end
    end

  always_ff @(posedge CLOCK or posedge RESET)
    if (RESET)
    begin
      sec_r <= tkr_pkg::RST_BCD_ZERO;
      min_r <= tkr_pkg::RST_BCD_ZERO;
      hr_r  <= tkr_pkg::RST_BCD_ZERO;
      wd_r  <= tkr_pkg::RST_BCD_ONE;
      dt_r  <= tkr_pkg::RST_BCD_ONE;
      mo_r  <= tkr_pkg::RST_BCD_ONE;
      yr_r  <= tkr_pkg::RST_BCD_ZERO;
    end
    else if (load)
    begin
      sec_r <= vis_r[1] & tkr_pkg::MSK_SECONDS;
      min_r <= vis_r[2] & tkr_pkg::MSK_MINUTES;
      hr_r  <= vis_r[3] & tkr_pkg::MSK_HOURS;
      wd_r  <= vis_r[4] & tkr_pkg::MSK_WEEKDAY;
      dt_r  <= vis_r[5] & tkr_pkg::MSK_DATE;
      mo_r  <= vis_r[6] & tkr_pkg::MSK_MONTH;
      yr_r  <= vis_r[7] & tkr_pkg::MSK_YEAR;
    end
    else if (tick && sub_r == 10'h3ff)
    begin
      sec_r <= (sec_r == 8'h59) ? 8'h00 : bcd_inc(sec_r);
      if (sec_r == 8'h59)
      begin
        min_r <= (min_r == 8'h59) ? 8'h00 : bcd_inc(min_r);
        if (min_r == 8'h59)
        begin
          hr_r <= (hr_r == 8'h23) ? 8'h00 : bcd_inc(hr_r);
          if (hr_r == 8'h23)
          begin
            wd_r <= (wd_r == 8'h07) ? 8'h01 : bcd_inc(wd_r);
            dt_r <= (dt_r == last_day(mo_r, yr_r)) ? 8'h01 : bcd_inc(dt_r);
            if (dt_r == last_day(mo_r, yr_r))
            begin
              mo_r <= (mo_r == 8'h12) ? 8'h01 : bcd_inc(mo_r);
              if (mo_r == 8'h12)
                yr_r <= (yr_r == 8'h99) ? 8'h00 : bcd_inc(yr_r);
            end
          end
        end
      end
    end

  //--------------------------------------------------------------
  // Visible registers: refresh, host writes, spare bits
  //--------------------------------------------------------------
  logic [7:0] cnt [8];
  logic [7:0] msk [8];
  assign cnt = '{8'h00, sec_r, min_r, hr_r, wd_r, dt_r, mo_r, yr_r};
  assign msk = '{8'h00, tkr_pkg::MSK_SECONDS, tkr_pkg::MSK_MINUTES, tkr_pkg::MSK_HOURS,
                 tkr_pkg::MSK_WEEKDAY, tkr_pkg::MSK_DATE, tkr_pkg::MSK_MONTH,
                 tkr_pkg::MSK_YEAR};

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_vis
      always_ff @(posedge CLOCK or posedge RESET)
        if (RESET)
          vis_r[g] <= (g == 0) ? tkr_pkg::RST_CONTROL : 8'h00;
        else if (wr_end && is_clk && ri == 3'(g))
          vis_r[g] <= din;
        else if (!frozen && g != 0)
          vis_r[g] <= (vis_r[g] & ~msk[g]) | cnt[g];
    end
  endgenerate

  //--------------------------------------------------------------
  // Read path
  //--------------------------------------------------------------
  logic [7:0] rd_byte;
  logic [7:0] dout_r;
  logic       drive_r;
  always_comb
  begin
    if (is_clk)
      rd_byte = vis_r[ri];
    else
      rd_byte = mem[addr[$clog2(MEM_WORDS)-1:0]];
    if (is_clk && ri == 3'h1 && osc_on && vis_r[4][tkr_pkg::BIT_FREQ])
      rd_byte[0] = toggle_r;
  end

  always_ff @(posedge CLOCK or posedge RESET)
    if (RESET)
    begin
      dout_r  <= 8'h00;
      drive_r <= 1'b0;
    end
    else
    begin
      dout_r  <= rd_byte;
      drive_r <= ~cs_n & ~oe_n & we_pin_n;
    end

  assign BUS.dev_dq_o             = dout_r;
  assign BUS.dev_dq_oe            = drive_r;
  assign BUS.power_fail_flag_n_o  = 1'b0;
  assign BUS.power_fail_flag_n_oe = ~pwr_ok;
endmodule
`default_nettype wire

// ### hdl/tkr_host.sv
// Purpose: Host end: runs single byte reads and writes on the SRAM bus
// Assumes: Device synchronises pins; phases must span its three-stage sync
// Notes: One request at a time; kept by caller and phasing
`timescale 1ns/1ps
`default_nettype none
module tkr_host #(
  parameter int PHASE_CYC = 8
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // User request
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic        REQ_WRITE,
  input  wire logic [18:0] REQ_ADDR,
  input  wire logic [7:0]  REQ_WDATA,
  // User answer
  output logic             RSP_VALID,
  output logic [7:0]       RSP_RDATA,
  output logic             POWER_FAIL_SEEN,
  // Bus
  tkr_bus_if.host          BUS
);
  // Phases must span the device synchroniser and fit the phase counter
  if (PHASE_CYC < 6 || PHASE_CYC > 256)
  begin : g_bad_params
    $error("tkr_host: PHASE_CYC out of range");
  end

  //--------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} tkr_hst_e;
  tkr_hst_e    st_r;
  logic [7:0]  cnt_r;
  logic        wr_r;
  logic [18:0] addr_r;
  logic [7:0]  wdat_r;
  logic [7:0]  rdat_r;
  logic        rsp_r;
  logic        pf_r;
  logic        phase_done;
  assign phase_done = (cnt_r == 8'(PHASE_CYC - 1));

  always_ff @(posedge CLOCK or posedge RESET)
    if (RESET)
    begin
      st_r   <= ST_IDLE;
      cnt_r  <= 8'h00;
      wr_r   <= 1'b0;
      addr_r <= '0;
      wdat_r <= 8'h00;
      rdat_r <= 8'h00;
      rsp_r  <= 1'b0;
      pf_r   <= 1'b0;
    end
    else
    begin
      rsp_r <= 1'b0;
      pf_r  <= ~BUS.power_fail_flag_n;
      cnt_r <= (st_r == ST_IDLE || phase_done) ? 8'h00 : cnt_r + 8'h01;
      case (st_r)
        ST_IDLE:
          if (REQ_VALID)
          begin
            wr_r   <= REQ_WRITE;
            addr_r <= REQ_ADDR;
            wdat_r <= REQ_WDATA;
            st_r   <= ST_SETUP;
          end
        ST_SETUP:
          if (phase_done)
            st_r <= ST_STROBE;
        ST_STROBE:
          if (phase_done)
          begin
            rdat_r <= BUS.dq;
            st_r   <= ST_HOLD;
          end
        ST_HOLD:
          if (phase_done)
          begin
            rsp_r <= 1'b1;
            st_r  <= ST_IDLE;
          end
        default:
          st_r <= ST_IDLE;
      endcase
    end

  assign REQ_READY       = (st_r == ST_IDLE);
  assign RSP_VALID       = rsp_r;
  assign RSP_RDATA       = rdat_r;
  assign POWER_FAIL_SEEN = pf_r;

  assign BUS.addr        = addr_r;
  assign BUS.chip_sel_n  = (st_r == ST_IDLE);
  assign BUS.wr_strobe_n = ~(wr_r && st_r == ST_STROBE);
  assign BUS.out_drv_n   = ~(!wr_r && st_r == ST_STROBE);
  assign BUS.host_dq_o   = wdat_r;
  assign BUS.host_dq_oe  = wr_r && st_r != ST_IDLE;
endmodule
`default_nettype wire

// ### verif/tkr_checker.sv
// Purpose: Bus-level assertions beside the host-device link
// Assumes: Device pins pass a three-stage synchroniser
// Notes:   Eight-cycle windows cover the synchroniser delay
`timescale 1ns/1ps
`default_nettype none
module tkr_checker (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RESET,
  // Supply monitor
  input wire logic        POWER_FAIL,
  // Bus
  input wire logic [18:0] addr,
  input wire logic        chip_sel_n,
  input wire logic        out_drv_n,
  input wire logic        wr_strobe_n,
  input wire logic        host_dq_oe,
  input wire logic        dev_dq_oe,
  input wire logic        power_fail_flag_n
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  // ----------------------------------------
  // Device side
  // ----------------------------------------
  a_drive_needs_access: assert property ($rose(dev_dq_oe) |->
    !$past(chip_sel_n, 2) && !$past(out_drv_n, 2) && wr_strobe_n)
    else $error("data driven without select and drive");
  a_idle_released: assert property (chip_sel_n [*8] |-> !dev_dq_oe)
    else $error("data driven while deselected");
  a_drv_released: assert property (out_drv_n [*8] |-> !dev_dq_oe)
    else $error("data driven with drive inactive");
  a_write_releases: assert property (!wr_strobe_n [*8] |-> !dev_dq_oe)
    else $error("data driven during write strobe");
  a_fail_blocks: assert property (POWER_FAIL [*8] |-> !dev_dq_oe)
    else $error("access served during power fail");
  a_fail_flag_low: assert property (POWER_FAIL [*8] |-> !power_fail_flag_n)
    else $error("power fail flag not low");
  a_flag_needs_fail: assert property (!POWER_FAIL [*8] |-> power_fail_flag_n)
    else $error("power fail flag low without fail");

  // ----------------------------------------
  // Host side
  // ----------------------------------------
  a_addr_stable: assert property ((!chip_sel_n && !wr_strobe_n) [*2] |-> $stable(addr))
    else $error("address moved during write");
  a_no_contention: assert property (dev_dq_oe |-> !host_dq_oe)
    else $error("both ends drive data");
  a_write_no_drive: assert property (!wr_strobe_n |-> out_drv_n && host_dq_oe)
    else $error("write without host data or with drive");

  c_read: cover property ($rose(dev_dq_oe));
  c_write: cover property ($fell(wr_strobe_n) && !chip_sel_n);
  c_fail: cover property ($fell(power_fail_flag_n));
endmodule
`default_nettype wire

// ### verif/tb_bytewide_timekeeping_sram_rtc.sv
// Purpose: Self-checking bench for host and timekeeping device
// Assumes: Short second (TICK_DIV 4), sixteen RAM bytes
// Notes:   Expected values come from a small model in the bench
`timescale 1ns/1ps
`default_nettype none
module tb_bytewide_timekeeping_sram_rtc;
  logic        clock = 1'h0;
  logic        reset = 1'h1;
  logic        power_fail = 1'h0;
  logic        req_valid = 1'h0;
  logic        req_ready;
  logic        req_write = 1'h0;
  logic [18:0] req_addr = 19'h00000;
  logic [7:0]  req_wdata = 8'h00;
  logic        rsp_valid;
  logic [7:0]  rsp_rdata;
  logic        power_fail_seen;
  logic [7:0]  q;
  logic [7:0]  s0;
  int          n;
  int          errors;
  int          samples_checked;
  int          model_ram [16];
  logic [7:0]  load_v [7] = '{8'h59, 8'h59, 8'h23, 8'h87, 8'h28, 8'h02, 8'h24};
  logic [7:0]  roll_v [7] = '{8'h00, 8'h00, 8'h00, 8'h81, 8'h29, 8'h02, 8'h24};

  tkr_bus_if bus ();
  tkr_device #(.MEM_WORDS(16), .TICK_DIV(4)) u_tkr_device (.CLOCK(clock), .RESET(reset),
    .POWER_FAIL(power_fail), .BUS(bus));
  tkr_host u_tkr_host (.CLOCK(clock), .RESET(reset), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .POWER_FAIL_SEEN(power_fail_seen), .BUS(bus));
  tkr_checker u_tkr_checker (.CLOCK(clock), .RESET(reset), .POWER_FAIL(power_fail),
    .addr(bus.addr), .chip_sel_n(bus.chip_sel_n), .out_drv_n(bus.out_drv_n),
    .wr_strobe_n(bus.wr_strobe_n), .host_dq_oe(bus.host_dq_oe), .dev_dq_oe(bus.dev_dq_oe),
    .power_fail_flag_n(bus.power_fail_flag_n));

  always #5 clock = ~clock;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One host request, bounded wait for its answer
  task automatic access(input logic wr, input logic [18:0] a, input logic [7:0] d);
    int k;
    @(negedge clock);
    check("ready when idle", {7'h00, req_ready}, 8'h01);
    req_valid = 1'h1;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    @(negedge clock);
    req_valid = 1'h0;
    check("ready while busy", {7'h00, req_ready}, 8'h00);
    k = 0;
    while (rsp_valid !== 1'h1 && k < 100)
    begin
      @(negedge clock);
      k++;
    end
    if (k == 100)
      errors++;
    q = rsp_rdata;
  endtask

  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    access(1'h1, a, d);
  endtask

  task automatic ctl(input logic [7:0] d);
    access(1'h1, tkr_pkg::OFS_CONTROL, d);
  endtask

  task automatic rd(input logic [18:0] a, input logic [7:0] exp);
    access(1'h0, a, 8'h00);
    check($sformatf("byte at %h", a), q, exp);
  endtask

  function automatic int bcd(input logic [7:0] v);
    return v[7:4] * 10 + v[3:0];
  endfunction

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h4440));
    repeat (3) @(posedge clock);
    @(negedge clock);
    reset = 1'h0;
    repeat (6) @(negedge clock);
    rd(tkr_pkg::OFS_CONTROL, tkr_pkg::RST_CONTROL);
    rd(tkr_pkg::OFS_MONTH, tkr_pkg::RST_BCD_ONE);
    for (int i = 0; i < 24; i++)
    begin
      n = (i < 16) ? i : $urandom_range(15, 0);
      model_ram[n] = $urandom_range(255, 0);
      wr(19'(n), 8'(model_ram[n]));
    end
    for (int i = 0; i < 16; i++)
      rd(19'(i), 8'(model_ram[i]));
    // Load 23:59:59 on 28 February of a leap year, the day before its last day
    ctl(8'h80);
    for (int i = 0; i < 7; i++)
      wr(tkr_pkg::OFS_SECONDS + 19'(i), load_v[i]);
    ctl(8'h00);
    repeat (4200) @(negedge clock);
    ctl(8'h55);
    rd(tkr_pkg::OFS_CONTROL, 8'h55);
    access(1'h0, tkr_pkg::OFS_SECONDS, 8'h00);
    s0 = q;
    check("seconds after load", {7'h00, s0 <= 8'h01}, 8'h01);
    for (int i = 1; i < 7; i++)
      rd(tkr_pkg::OFS_SECONDS + 19'(i), roll_v[i]);
    repeat (4500) @(negedge clock);
    rd(tkr_pkg::OFS_SECONDS, s0);
    ctl(8'h15);
    repeat (tkr_pkg::READ_CLR_CYC) @(negedge clock);
    ctl(8'h40);
    access(1'h0, tkr_pkg::OFS_SECONDS, 8'h00);
    check("seconds advance", 8'((bcd(q) - bcd(s0) + 1) / 2), 8'h07);
    // Stopped oscillator holds the loaded seconds
    ctl(8'h80);
    wr(tkr_pkg::OFS_SECONDS, 8'h85);
    ctl(8'h00);
    repeat (4500) @(negedge clock);
    ctl(8'h40);
    rd(tkr_pkg::OFS_SECONDS, 8'h85);
    // Frequency probe on seconds bit 0
    ctl(8'h80);
    wr(tkr_pkg::OFS_WEEKDAY, 8'h41);
    wr(tkr_pkg::OFS_SECONDS, 8'h00);
    ctl(8'h00);
    n = 0;
    for (int i = 0; i < 16; i++)
    begin
      access(1'h0, tkr_pkg::OFS_SECONDS, 8'h00);
      n = n | (1 << q[0]);
    end
    check("probe bit0 values", 8'(n), 8'h03);
    // Power fail blocks access and lowers the flag
    model_ram[3] = 8'h5a;
    wr(19'h00003, 8'(model_ram[3]));
    @(negedge clock);
    power_fail = 1'h1;
    repeat (10) @(negedge clock);
    check("fail flag", {7'h00, bus.power_fail_flag_n}, 8'h00);
    check("fail seen", {7'h00, power_fail_seen}, 8'h01);
    wr(19'h00003, 8'ha5);
    rd(19'h00003, 8'hff);
    @(negedge clock);
    power_fail = 1'h0;
    repeat (10) @(negedge clock);
    check("flag released", {7'h00, bus.power_fail_flag_n}, 8'h01);
    rd(19'h00003, 8'(model_ram[3]));
    results();
  end

  initial
  begin
    #900_000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
